//--- bench/cache_ctl_props.sv
// port assertions for the cache control block
`timescale 1ns/10ps
`default_nettype none
module cache_ctl_props (
  input wire logic                    ref_clk,
  input wire logic                    rst_n,
  input wire cache_ctl_pkg::cpu_bus_t cpu,
  input wire logic                    memory_done_ack,
  input wire logic                    sync_cycle_end,
  input wire logic                    bus_error_out,
  input wire logic                    halt_out,
  input wire logic                    async_size_ack_hi,
  input wire logic                    async_size_ack_lo,
  input wire logic                    pipeline_cycle_done,
  input wire cache_ctl_pkg::mem_req_t mem,
  input wire logic                    validity_update_strobe,
  input wire logic                    validity_write_strobe,
  input wire logic                    tag_write_strobe
);
  import cache_ctl_pkg::*;
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // acknowledge then termination one clock later
  sequence s_ack_end; pipeline_cycle_done ##1 sync_cycle_end; endsequence
  // validity read then write on the next clock
  sequence s_rmw; validity_update_strobe ##1 validity_write_strobe; endsequence
  property p_async; !async_size_ack_hi && !async_size_ack_lo; endproperty
  property p_retry;
    (bus_error_out || halt_out) |-> bus_error_out && halt_out && $past(cpu.read);
  endproperty
  property p_ack_end; pipeline_cycle_done |-> s_ack_end; endproperty
  property p_wr_fast; $rose(mem.req) && mem.write |-> s_ack_end; endproperty
  property p_align; mem.req && !mem.write |-> mem.addr[1:0] == 2'h0; endproperty
  property p_hold;
    mem.req && !memory_done_ack |=> mem.req && $stable(mem.addr);
  endproperty
  property p_release; $fell(mem.req) |-> $past(memory_done_ack); endproperty
  property p_no_fast; mem.req && !mem.write |-> !sync_cycle_end; endproperty
  property p_tag;
    tag_write_strobe |-> validity_write_strobe && $past(mem.req && !mem.write);
  endproperty
  property p_coh; cpu.grant_ack && validity_update_strobe |-> s_rmw; endproperty
  property p_upd;
    validity_update_strobe && !cpu.grant_ack |-> mem.req && !mem.write;
  endproperty
  a_async: assert property (p_async)
    else $error("async acknowledge driven");
  a_retry: assert property (p_retry)
    else $error("bus error and halt not paired on a read");
  a_ack_end: assert property (p_ack_end)
    else $error("no termination after pipeline acknowledge");
  a_wr_fast: assert property (p_wr_fast)
    else $error("write into empty pipeline not acknowledged at once");
  a_align: assert property (p_align)
    else $error("memory read not longword aligned");
  a_hold: assert property (p_hold)
    else $error("pending request changed before acknowledge");
  a_release: assert property (p_release)
    else $error("request dropped without memory acknowledge");
  a_no_fast: assert property (p_no_fast)
    else $error("fast termination during memory read");
  a_tag: assert property (p_tag)
    else $error("tag strobe outside a read miss update");
  a_coh: assert property (p_coh)
    else $error("coherency update without validity write");
  a_upd: assert property (p_upd)
    else $error("validity read outside memory read");
endmodule
bind cache_ctl cache_ctl_props i_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .cpu(cpu), .mem(mem),
  .memory_done_ack(memory_done_ack), .sync_cycle_end(sync_cycle_end),
  .bus_error_out(bus_error_out), .halt_out(halt_out),
  .async_size_ack_hi(async_size_ack_hi),
  .async_size_ack_lo(async_size_ack_lo),
  .pipeline_cycle_done(pipeline_cycle_done),
  .validity_update_strobe(validity_update_strobe),
  .validity_write_strobe(validity_write_strobe),
  .tag_write_strobe(tag_write_strobe)
);
`default_nettype wire

//--- bench/cache_ctl_tb.sv
// self-checking bench for the cache control block
`timescale 1ns/10ps
`default_nettype none
module cache_ctl_tb;
  import cache_ctl_pkg::*;
  logic        ref_clk, rst_n, jmp, flush_req_n, ack; // clock and pins
  cpu_bus_t    cpu;            // processor pins
  mem_req_t    mem;            // memory request
  logic        sce, bus_error_in, halt, ahi, alo, msel, cfl, pdone, vus, vws, tws;
  logic        hsel, hwrite, hrdy, hresp, inh, lck, sdis;
  logic [31:0] haddr, hwdata, hrdata, a, b, d, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  lag;            // partner memory delay
  int          bad_count, compares, seed, L, lat;
  int          vm [4096];      // expected validity bits
  int          tm [4096];      // expected stored tags
  logic        be;
  logic [1:0]  sp;             // space decode seen on the strobe edge
  cache_ctl i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .cpu(cpu), .mem(mem),
    .cache_disable_jumper(jmp), .flush_req_n(flush_req_n),
    .memory_done_ack(ack), .sync_cycle_end(sce), .bus_error_out(bus_error_in),
    .halt_out(halt), .async_size_ack_hi(ahi), .async_size_ack_lo(alo),
    .memory_space_select(msel), .cacheable_space_flag(cfl),
    .pipeline_cycle_done(pdone), .validity_update_strobe(vus),
    .validity_write_strobe(vws), .tag_write_strobe(tws), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
    .hresp(hresp)
  );
  mem_model i_mem (.ref_clk(ref_clk), .rst_n(rst_n), .mem(mem), .lag(lag),
    .memory_done_ack(ack));
  // free-running system clock
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk_i(string n, int e, int g);
    compares++;
    if (e != g)
    begin
      bad_count++;
      $display("mismatch %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic chk_v(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (e !== g)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one single word transfer; entered just after a rising edge
  task automatic ahb(logic [31:0] ad, logic w, logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= ad;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hrdy !== 1'b1);
    d = hrdata;
    chk_v("hresp", 32'h0, hresp);
  endtask
  // processor cycle: strobe held one clock past the answer, then one idle clock
  task automatic cyc(logic [31:0] ad, logic [2:0] f, logic rd,
    output logic [31:0] ma);
    lat = -1;
    be = 1'b0;
    ma = 'x;
    cpu <= '{1'b1, ad, f, rd, inh, lck, 1'b0};
    for (int n = 0; n < 30 && lat < 0; n++)
    begin
      @(posedge ref_clk);
      #1;
      if (n == 0)
        sp = {msel, cfl};
      if (mem.req === 1'b1)
        ma = mem.addr;
      if (bus_error_in === 1'b1)
        be = 1'b1;
      if (bus_error_in === 1'b1 || sce === 1'b1)
        lat = n + 1; // clocks since the strobe was driven
    end
    @(posedge ref_clk);
    cpu.strobe <= 1'b0;
    @(posedge ref_clk);
  endtask
  // predicted access: latency, retry, alignment, validity mirror
  task automatic access(logic [31:0] ad, logic [2:0] f, logic rd);
    int ms, cch, hit, ix, sl;
    logic [31:0] ma;
    ix = ad[15:4];
    sl = ad[3:2];
    ms = (f inside {3'h1, 3'h2, 3'h5, 3'h6}) && ad < MEM_LIMIT;
    cch = ms && !(inh | lck | jmp | sdis);
    hit = cch && tm[ix] == ad[31:16] && vm[ix][sl];
    #1;
    while (mem.req !== 1'b0) // drain any pending write first
      @(negedge ref_clk);
    @(posedge ref_clk);
    cyc(ad, f, rd, ma);
    chk_i("latency", !ms ? -1 : !rd ? 2 : cch ? 1 : 4 + L, lat);
    chk_v("space", {30'h0, ms[0], cch[0]}, {30'h0, sp});
    chk_v("retry", rd && cch && !hit, be);
    if (be === 1'b1)
    begin
      repeat (2) @(posedge ref_clk);
      cyc(ad, f, rd, ma);
      chk_i("reissue", 4 + L, lat);
      vm[ix] = (tm[ix] == ad[31:16] ? vm[ix] : 0) | (1 << sl);
      tm[ix] = ad[31:16];
    end
    if (rd && ms && !hit)
      chk_v("mem addr", {ad[31:2], 2'h0}, ma);
  endtask
  // alternate master invalidates a line, strobe held three clocks
  task automatic coh(logic [31:0] ad);
    cpu <= '{1'b1, ad, 3'h1, 1'b0, 1'b0, 1'b0, 1'b1};
    repeat (3) @(posedge ref_clk);
    cpu.strobe <= 1'b0;
    @(posedge ref_clk);
    cpu.grant_ack <= 1'b0;
    repeat (2) @(posedge ref_clk);
    if (tm[ad[15:4]] == ad[31:16])
      vm[ad[15:4]] = 0;
  endtask
  // main sequence
  initial
  begin
    seed = 32'h921c;
    {rst_n, jmp, inh, lck, sdis, hsel, hwrite, htrans} = '0;
    {cpu, haddr, hwdata} = '0;
    flush_req_n = 1'b1;
    hsize = 3'h2;
    lag = 4'h2;
    L = 2;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk_v("ready", 32'h1, hrdy);
    chk_v("async", 32'h0, {ahi, alo});
    @(posedge ref_clk);
    ahb({24'h0, CTRL_OFS}, 1'b1, 32'h3);
    ahb({24'h0, CTRL_OFS}, 1'b0, 32'h0);
    chk_v("ctrl", 32'h2, d);
    ahb(32'h10, 1'b0, 32'h0);
    chk_v("unmapped", UNMAPPED_RD, d);
    sdis = 1'b1;
    r = $random(seed);
    a = {4'h0, r[27:4], 4'h0};
    b = a ^ 32'h0001_0000; // same line, other tag
    access(a | 32'h3, 3'h1, 1'b1);
    ahb({24'h0, CTRL_OFS}, 1'b1, 32'h0);
    sdis = 1'b0;
    ahb({24'h0, STAT_OFS}, 1'b0, 32'h0);
    chk_v("status", 32'h0, d);
    for (int f = 0; f < 8; f++)
      access(a, f[2:0], 1'b0);
    access(MEM_LIMIT, 3'h1, 1'b0);
    access(MEM_LIMIT - 32'h4, 3'h1, 1'b0);
    access(a | 32'h3, 3'h2, 1'b1);
    access(a, 3'h2, 1'b1);
    access(a + 32'h4, 3'h2, 1'b1);
    access(a, 3'h2, 1'b1);
    access(b + 32'h8, 3'h2, 1'b1);
    access(a, 3'h2, 1'b1);
    access(b, 3'h2, 1'b1);
    access(b, 3'h1, 1'b0);
    lag <= 4'h8;
    L = 8;
    wait (mem.req === 1'b0); // timed write needs an empty pipeline
    @(posedge ref_clk);
    cyc(b, 3'h1, 1'b0, r);
    chk_i("write", 2, lat);
    cyc(b, 3'h1, 1'b1, r);
    chk_i("hit in write", 1, lat);
    cyc(b + 32'h4, 3'h1, 1'b0, r);
    chk_i("held write", 1, int'(lat > 2));
    lag <= 4'h0;
    L = 0;
    for (int i = 0; i < 3; i++)
    begin
      {inh, lck, jmp} <= 3'h1 << i;
      repeat (4) @(posedge ref_clk);
      access(b + 32'hc, 3'h6, 1'b1);
    end
    {inh, lck, jmp} <= 3'h0;
    repeat (4) @(posedge ref_clk);
    access(b + 32'hc, 3'h6, 1'b1);
    coh(b);
    access(b, 3'h2, 1'b1);
    ahb({24'h0, CTRL_OFS}, 1'b1, 32'h1);
    vm = '{default: 0};
    access(b, 3'h2, 1'b1);
    flush_req_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    flush_req_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    vm = '{default: 0};
    access(b, 3'h2, 1'b1);
    lag <= 4'h3;
    L = 3;
    repeat (24)
    begin
      r = $random(seed);
      access((r[0] ? a : b) + {r[3:2], 2'h0}, 3'h5, r[4]);
    end
    conclude;
  end
  // hang guard
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    conclude;
  end
endmodule
`default_nettype wire

//--- bench/mem_model.sv
// shared memory partner: one acknowledge per request after a set lag
`timescale 1ns/10ps
`default_nettype none
module mem_model (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire cache_ctl_pkg::mem_req_t mem,
  input  wire logic [3:0]              lag,
  output var  logic                    memory_done_ack
);
  import cache_ctl_pkg::*;
  logic [3:0] cnt;   // cycles waited on this request
  logic       spent; // acked, request not yet dropped
  // spent stops a second ack while the block still holds the request
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 4'h0;
      spent <= 1'b0;
      memory_done_ack <= 1'b0;
    end
    else
    begin
      memory_done_ack <= 1'b0;
      if (spent)
        spent <= mem.req;
      else if (mem.req && cnt >= lag)
      begin
        memory_done_ack <= 1'b1;
        spent <= 1'b1;
        cnt <= 4'h0;
      end
      else if (mem.req)
        cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- core/cache_ctl.sv
// cache control: decode, termination, retry, tag and validity stores
`timescale 1ns/10ps
`default_nettype none
module cache_ctl #(
  parameter int IDX_N = 4096 // lines in tag and validity stores
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire cache_ctl_pkg::cpu_bus_t cpu,
  input  wire logic                    cache_disable_jumper,
  input  wire logic                    flush_req_n,
  input  wire logic                    memory_done_ack,
  output var  logic                    sync_cycle_end,
  output var  logic                    bus_error_out,
  output var  logic                    halt_out,
  output var  logic                    async_size_ack_hi,
  output var  logic                    async_size_ack_lo,
  output var  logic                    memory_space_select,
  output var  logic                    cacheable_space_flag,
  output var  logic                    pipeline_cycle_done,
  output var  cache_ctl_pkg::mem_req_t mem,
  output var  logic                    validity_update_strobe,
  output var  logic                    validity_write_strobe,
  output var  logic                    tag_write_strobe,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output var  logic [31:0]             hrdata,
  output var  logic                    hreadyout,
  output var  logic                    hresp
);
  import cache_ctl_pkg::*;

  // stores: tag has no reset, validity clears on reset and flush
  logic [15:0] tag_store [IDX_N];
  logic [3:0]  valid_store [IDX_N];

  // pin synchronisers for the jumper and the flush request
  logic [1:0] jmp_sync;
  logic [1:0] fl_sync;

  // control state
  state_t      state;
  state_t      next_state;
  logic        retry_pend;       // a miss awaits its reissue
  logic        next_retry_pend;
  logic [31:0] retry_addr;       // address of the missed read
  logic [31:0] next_retry_addr;
  logic        is_retry;         // current memory read is a retry
  logic        next_is_retry;
  logic [3:0]  new_valid;        // modified validity copy
  logic [3:0]  next_new_valid;
  logic [31:0] cyc_addr;         // held address of this cycle
  logic [31:0] next_cyc_addr;
  logic        next_sync_cycle_end;
  logic        next_bus_error_in;
  logic        next_pcd;
  logic        next_vus;
  logic        next_vws;
  logic        next_tws;
  mem_req_t    next_mem;
  logic        next_msel;
  logic        next_cach;
  logic        do_flush;         // whole-store clear this cycle

  // register slave state
  logic [1:0]  ctrl;             // bit0 flush pulse, bit1 disable
  logic [1:0]  next_ctrl;
  logic        dp_wr;            // data phase is a write
  logic        next_dp_wr;
  logic [7:0]  dp_ofs;
  logic [7:0]  next_dp_ofs;
  logic [31:0] next_hrdata;

  // decode of the live cycle
  logic [IDX_W-1:0] idx;
  logic [1:0]       sel;
  logic [15:0]      stored_tag;
  logic [3:0]       stored_valid;
  logic [SLICES-1:0] slice_tag_equal;
  logic             tag_equal;
  logic             hit;
  logic             mem_space;
  logic             cacheable;
  logic             pipe_full;
  logic             reissue;

  assign idx          = cpu.addr[IDX_LSB +: IDX_W];            // RULE_14
  assign sel          = cpu.addr[SEL_LSB +: 2];                // RULE_14
  assign stored_tag   = tag_store[idx];
  assign stored_valid = valid_store[idx];

  // four nibble comparators, like the sliced tag parts
  genvar g;
  generate
    for (g = 0; g < SLICES; g++)
    begin : g_slice
      assign slice_tag_equal[g] =
        stored_tag[g*SLICE_W +: SLICE_W] ==
        cpu.addr[TAG_LSB + g*SLICE_W +: SLICE_W];
    end
  endgenerate

  assign tag_equal = &slice_tag_equal;                         // RULE_15
  assign hit       = tag_equal && stored_valid[sel];           // RULE_13 RULE_17
  // program or data space, supervisor or user
  assign mem_space = (cpu.addr < MEM_LIMIT) &&
                     (cpu.fc inside {3'h1, 3'h2, 3'h5, 3'h6}); // RULE_01
  assign cacheable = mem_space && !cpu.inhibit && !cpu.locked &&
                     !cpu.grant_ack && !jmp_sync[1] &&
                     !ctrl[CTRL_DIS];                          // RULE_02
  assign pipe_full = mem.req && mem.write;
  assign reissue   = retry_pend && cpu.read &&
                     cpu.addr == retry_addr;
  assign do_flush  = !fl_sync[1] || ctrl[CTRL_FLUSH];          // RULE_16

  // cycle sequencer, next values
  always_comb
  begin
    next_state      = state;
    next_retry_pend = retry_pend;
    next_retry_addr = retry_addr;
    next_is_retry   = is_retry;
    next_new_valid  = new_valid;
    next_cyc_addr   = cyc_addr;
    next_sync_cycle_end      = 1'b0;
    next_bus_error_in       = 1'b0;
    next_pcd        = 1'b0;
    next_vus        = 1'b0;
    next_vws        = 1'b0;
    next_tws        = 1'b0;
    next_mem        = mem;
    next_msel       = mem_space && cpu.strobe && !cpu.grant_ack;
    next_cach       = cacheable && cpu.strobe;
    // background drain of the one-deep write pipeline
    if (mem.req && mem.write && memory_done_ack)
      next_mem.req = 1'b0;
    unique case (state)
      ST_IDLE:
      begin
        if (cpu.strobe && cpu.grant_ack && !cpu.read)
        begin
          // coherency: invalidate a matching line
          next_cyc_addr = cpu.addr;
          next_state    = ST_COH;
          if (tag_equal)
          begin
            next_vus       = 1'b1;
            next_new_valid = 4'h0;                             // RULE_21
            next_state     = ST_CVW;
          end
        end
        else if (cpu.strobe && mem_space && !cpu.grant_ack)
        begin
          next_cyc_addr = cpu.addr;
          if (cpu.read && cacheable && !reissue)
          begin
            // fast path, even with a write draining
            next_state = ST_DONE;
            if (hit)
              next_sync_cycle_end = 1'b1;                               // RULE_03 RULE_08
            else
            begin
              next_bus_error_in       = 1'b1;                          // RULE_09
              next_retry_pend = 1'b1;
              next_retry_addr = cpu.addr;
            end
          end
          else if (!pipe_full && !(mem.req && !mem.write))     // RULE_07
          begin
            if (cpu.read)
            begin
              // retry or noncacheable read through memory
              next_mem.req   = 1'b1;
              next_mem.write = 1'b0;
              next_mem.addr  = {cpu.addr[31:2], 2'b00};        // RULE_05
              next_is_retry  = reissue;
              next_retry_pend = 1'b0;
              next_state     = ST_MEMRD;
              if (reissue && cacheable)
              begin
                // read half of the validity read-modify-write
                next_vus = 1'b1;                               // RULE_19
                next_new_valid = (tag_equal ? stored_valid : 4'h0)
                               | (4'h1 << sel);                // RULE_20
              end
              else
                next_is_retry = 1'b0;
            end
            else
            begin
              // write is taken into the pipeline at once
              next_mem.req   = 1'b1;
              next_mem.write = 1'b1;
              next_mem.addr  = cpu.addr;
              next_pcd       = 1'b1;                           // RULE_24
              next_state     = ST_TERM;                        // RULE_06
            end
          end
        end
      end
      ST_MEMRD:
      begin
        if (memory_done_ack)
        begin
          next_mem.req = 1'b0;
          next_pcd     = 1'b1;                                 // RULE_23
          next_state   = ST_TERM;
          if (is_retry)
          begin
            next_vws = 1'b1;                                   // RULE_19 RULE_22
            next_tws = 1'b1;                                   // RULE_22
          end
        end
      end
      ST_TERM:
      begin
        next_sync_cycle_end = 1'b1;                                     // RULE_04 RULE_11
        next_state = ST_DONE;
      end
      ST_CVW:
      begin
        next_vws   = 1'b1;                                     // RULE_22
        next_state = ST_COH;
      end
      ST_COH:
        if (!cpu.strobe)
          next_state = ST_IDLE;
      ST_DONE:
        if (!cpu.strobe)
          next_state = ST_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state                  <= ST_IDLE;
      retry_pend             <= 1'b0;
      retry_addr             <= 32'h0000_0000;
      is_retry               <= 1'b0;
      new_valid              <= 4'h0;
      cyc_addr               <= 32'h0000_0000;
      sync_cycle_end         <= 1'b0;
      bus_error_out          <= 1'b0;
      halt_out               <= 1'b0;
      pipeline_cycle_done    <= 1'b0;
      validity_update_strobe <= 1'b0;
      validity_write_strobe  <= 1'b0;
      tag_write_strobe       <= 1'b0;
      mem                    <= '0;
      memory_space_select    <= 1'b0;
      cacheable_space_flag   <= 1'b0;
      async_size_ack_hi      <= 1'b0;
      async_size_ack_lo      <= 1'b0;
      jmp_sync               <= 2'h0;
      fl_sync                <= 2'h3;
    end
    else
    begin
      state                  <= next_state;
      retry_pend             <= next_retry_pend;
      retry_addr             <= next_retry_addr;
      is_retry               <= next_is_retry;
      new_valid              <= next_new_valid;
      cyc_addr               <= next_cyc_addr;
      sync_cycle_end         <= next_sync_cycle_end;                    // RULE_12
      bus_error_out          <= next_bus_error_in;                     // RULE_09
      halt_out               <= next_bus_error_in;                     // RULE_10
      pipeline_cycle_done    <= next_pcd;
      validity_update_strobe <= next_vus;
      validity_write_strobe  <= next_vws;
      tag_write_strobe       <= next_tws;
      mem                    <= next_mem;
      memory_space_select    <= next_msel;
      cacheable_space_flag   <= next_cach;
      // left free for peripherals, never driven active
      async_size_ack_hi      <= 1'b0;                          // RULE_12
      async_size_ack_lo      <= 1'b0;                          // RULE_12
      jmp_sync               <= {jmp_sync[0], cache_disable_jumper};
      fl_sync                <= {fl_sync[0], flush_req_n};
    end
  end

  // validity store: cleared whole, written only on a write strobe
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < IDX_N; i++)
        valid_store[i] <= 4'h0;                                // RULE_16
    end
    else if (do_flush)
    begin
      for (int i = 0; i < IDX_N; i++)
        valid_store[i] <= 4'h0;                                // RULE_16
    end
    else if (validity_write_strobe)
      valid_store[cyc_addr[IDX_LSB +: IDX_W]] <= new_valid;    // RULE_18
  end

  // tag store: a data array, no reset needed
  always_ff @(posedge ref_clk)
  begin
    if (tag_write_strobe)
      tag_store[cyc_addr[IDX_LSB +: IDX_W]] <=
        cyc_addr[31:TAG_LSB];                                  // RULE_25
  end

  // register slave: zero wait, data read back from a flop
  always_comb
  begin
    next_ctrl   = ctrl;
    next_dp_wr  = 1'b0;
    next_dp_ofs = dp_ofs;
    next_hrdata = hrdata;
    // flush bit self-clears after one cycle
    next_ctrl[CTRL_FLUSH] = 1'b0;
    if (dp_wr && dp_ofs == CTRL_OFS)
      next_ctrl = hwdata[1:0];
    if (hsel && htrans[1] && hready)
    begin
      next_dp_wr  = hwrite;
      next_dp_ofs = haddr[7:0];
      if (haddr[7:0] == CTRL_OFS)
        next_hrdata = {30'h0, ctrl[CTRL_DIS], 1'b0}; // flush pulse reads 0
      else if (haddr[7:0] == STAT_OFS)
        next_hrdata = {26'h0, jmp_sync[1], is_retry, retry_pend,
                       mem.req && !mem.write, pipe_full,
                       state != ST_IDLE};
      else
        next_hrdata = UNMAPPED_RD;
    end
  end

  // register slave flops
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl      <= CTRL_RESET;
      dp_wr     <= 1'b0;
      dp_ofs    <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end
    else
    begin
      ctrl      <= next_ctrl;
      dp_wr     <= next_dp_wr;
      dp_ofs    <= next_dp_ofs;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- core/cache_ctl_pkg.sv
// constants and carrier types for the cache hit, retry and validity control
// Overview of operation
// [RULE_01] memory select: lowest 268M bytes, program/data space
// [RULE_02] cacheable: memory, no inhibit, lock, grant, jumper
// [RULE_03] cacheable reads terminate from address alone
// [RULE_04] other memory cycles end after pipeline done
// [RULE_05] memory reads are aligned 32-bit longwords
// [RULE_06] writes finish in three clocks, pipeline empty
// [RULE_07] full pipeline holds off later memory cycles
// [RULE_08] read hits continue during buffered write
// [RULE_09] read miss raises bus error and halt
// [RULE_10] processor ends, idles two clocks, reissues
// [RULE_11] reissued cycle suppresses fast termination path
// [RULE_12] only synchronous termination; async acks free
// [RULE_13] hit needs four slice matches and valid
// [RULE_14] tag A31-A16, index A15-A4, select A3-A2
// [RULE_15] slice compares ANDed into one equality
// [RULE_16] reset or flush clears all validity
// [RULE_17] four validity bits per line, A3:A2 selects
// [RULE_18] only read misses set validity bits
// [RULE_19] validity read-modify-write with update, write strobes
// [RULE_20] set addressed bit; others kept only on match
// [RULE_21] coherency hit clears the four validity bits
// [RULE_22] tag strobe on misses; validity also coherency
// [RULE_23] reads wait for memory done acknowledge
// [RULE_24] write with pipeline free acknowledged at once
// [RULE_25] miss update writes tag A31-A16 at index
package cache_ctl_pkg;
  localparam logic [31:0] MEM_LIMIT   = 32'h1000_0000; // 268M bytes
  localparam int          TAG_LSB     = 16;            // tag A31-A16
  localparam int          IDX_LSB     = 4;             // index A15-A4
  localparam int          IDX_W       = 12;
  localparam int          SEL_LSB     = 2;             // longword A3:A2
  localparam int          SLICES      = 4;
  localparam int          SLICE_W     = 4;
  localparam logic [7:0]  CTRL_OFS    = 8'h00;         // control word
  localparam logic [7:0]  STAT_OFS    = 8'h04;         // status word
  localparam int          CTRL_FLUSH  = 0;             // write 1: flush
  localparam int          CTRL_DIS    = 1;             // soft disable
  localparam logic [1:0]  CTRL_RESET  = 2'h0;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
  // processor cycle as seen at the pins
  typedef struct packed {
    logic        strobe;    // address strobe, active high
    logic [31:0] addr;
    logic [2:0]  fc;        // function code
    logic        read;      // 1 read, 0 write
    logic        inhibit;   // cache_inhibit_out
    logic        locked;    // locked_rmw_cycle
    logic        grant_ack; // bus_grant_ack
  } cpu_bus_t;
  // request towards shared memory
  typedef struct packed {
    logic        req;
    logic        write;
    logic [31:0] addr;
  } mem_req_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_DONE, ST_MEMRD, ST_TERM, ST_COH, ST_CVW
  } state_t;
endpackage
